// *** rtl/pbi_top.sv ***
// Two-input push-button evaluation with Avalon-MM configuration
`timescale 1ns/1ns
`include "pbi_defines.svh"
module pbi_top
	import pbi_pkg::*;
#(
	parameter int MS_CYCLES = `PBI_MS_CYCLES,
	parameter int RATE_MS = `PBI_RATE_MS
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [1:0] button_in,
	input wire logic bus_ok,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic tg_valid,
	output logic tg_chan,
	output pbi_kind_t tg_kind,
	output logic [3:0] tg_data
);
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		return r;
	endfunction

	// Returns {send, value} for a switching command applied to the object
	function automatic logic [1:0] sw_cmd(input logic [1:0] cmd, input logic obj);
		logic [1:0] r;
		r = 2'h0;
		unique case (cmd)
			`PBI_CMD_NONE: r = 2'h0;
			`PBI_CMD_A: r = 2'h2;
			`PBI_CMD_B: r = 2'h3;
			`PBI_CMD_TOG: r = {1'b1, ~obj};
		endcase
		return r;
	endfunction

	logic [13:0] pre_ff, nxt_pre;
	logic [15:0] start_ff, nxt_start;
	logic bus_s1_ff, bus_s2_ff, bus_prev_ff;
	logic [1:0] in_s1_ff, in_s2_ff;
	logic startup_act, rate_block;
	logic [31:0] ctrl_ff, nxt_ctrl;
	logic [31:0] cfg_ff [2];
	logic [31:0] nxt_cfg [2];
	logic [31:0] tim_ff [2];
	logic [31:0] nxt_tim [2];
	logic [31:0] rep_ff [2];
	logic [31:0] nxt_rep [2];
	logic [31:0] rdata_ff, nxt_rdata;
	logic wait_ff, nxt_wait;
	pbi_state_t state_ff [2];
	pbi_state_t nxt_state [2];
	logic [15:0] timer_ff [2];
	logic [15:0] nxt_timer [2];
	logic [15:0] cyc_ff [2];
	logic [15:0] nxt_cyc [2];
	logic [1:0] prev_ff, nxt_prev;
	logic [1:0] obj_ff, nxt_obj;
	logic [1:0] bdir_ff, nxt_bdir;
	logic [1:0] due_ff, nxt_due;
	logic [1:0] ret_ff, nxt_ret;
	logic tgv_ff, nxt_tgv;
	logic tgc_ff, nxt_tgc;
	pbi_kind_t tgk_ff, nxt_tgk;
	logic [3:0] tgd_ff, nxt_tgd;
	logic act_c, cs_c, rise_c, fall_c, proc_c;

	assign startup_act = start_ff < ctrl_ff[15:0];
	assign rate_block = ctrl_ff[`PBI_CT_RATE] && (start_ff < RATE_MS[15:0]);
	assign avs_readdata = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign tg_valid = tgv_ff;
	assign tg_chan = tgc_ff;
	assign tg_kind = tgk_ff;
	assign tg_data = tgd_ff;

	// Startup timebase; restarted by bus voltage return
	always_comb
	begin
		nxt_pre = (pre_ff == 14'(MS_CYCLES - 1)) ? 14'h0 : pre_ff + 14'h1;
		nxt_start = start_ff;
		if (bus_s2_ff && !bus_prev_ff)
			nxt_start = 16'h0;
		else if (pre_ff == 14'h0 && start_ff != 16'hffff)
			nxt_start = start_ff + 16'h1;
	end

	// One wait state: waitrequest drops the cycle after a request is seen
	always_comb
	begin
		nxt_wait = !((avs_read || avs_write) && wait_ff);
		nxt_rdata = rdata_ff;
		nxt_ctrl = ctrl_ff;
		nxt_cfg = cfg_ff;
		nxt_tim = tim_ff;
		nxt_rep = rep_ff;
		if (avs_read && wait_ff)
		begin
			unique case (avs_address)
				`PBI_OFS_CTRL: nxt_rdata = ctrl_ff;
				`PBI_OFS_CFG0: nxt_rdata = cfg_ff[0];
				`PBI_OFS_CFG1: nxt_rdata = cfg_ff[1];
				`PBI_OFS_TIM0: nxt_rdata = tim_ff[0];
				`PBI_OFS_TIM1: nxt_rdata = tim_ff[1];
				`PBI_OFS_REP0: nxt_rdata = rep_ff[0];
				`PBI_OFS_REP1: nxt_rdata = rep_ff[1];
				`PBI_OFS_STAT: nxt_rdata = {11'h0, state_ff[1], 3'h0, state_ff[0], 2'h0,
					rate_block, startup_act, bdir_ff, obj_ff};
			endcase
		end
		if (avs_write && !wait_ff)
		begin
			unique case (avs_address)
				`PBI_OFS_CTRL: nxt_ctrl = be_merge(ctrl_ff, avs_writedata, avs_byteenable);
				`PBI_OFS_CFG0: nxt_cfg[0] = be_merge(cfg_ff[0], avs_writedata, avs_byteenable);
				`PBI_OFS_CFG1: nxt_cfg[1] = be_merge(cfg_ff[1], avs_writedata, avs_byteenable);
				`PBI_OFS_TIM0: nxt_tim[0] = be_merge(tim_ff[0], avs_writedata, avs_byteenable);
				`PBI_OFS_TIM1: nxt_tim[1] = be_merge(tim_ff[1], avs_writedata, avs_byteenable);
				`PBI_OFS_REP0: nxt_rep[0] = be_merge(rep_ff[0], avs_writedata, avs_byteenable);
				`PBI_OFS_REP1: nxt_rep[1] = be_merge(rep_ff[1], avs_writedata, avs_byteenable);
				`PBI_OFS_STAT: nxt_ctrl = ctrl_ff;
			endcase
		end
	end

	// Channels take turns on the first two cycles of each millisecond, so two
	// telegrams never collide on the single output and no queue is needed.
	always_comb
	begin
		logic [31:0] cfg;
		logic [1:0] fn, rcmd, sc;
		logic [15:0] tmr;
		logic snd, dir, val;
		pbi_kind_t kind;
		logic [3:0] dat;
		cfg = 32'h0;
		fn = 2'h0;
		rcmd = 2'h0;
		sc = 2'h0;
		tmr = 16'h0;
		snd = 1'b0;
		dir = 1'b0;
		val = 1'b0;
		kind = PBI_TG_NONE;
		dat = 4'h0;
		nxt_state = state_ff;
		nxt_timer = timer_ff;
		nxt_cyc = cyc_ff;
		nxt_prev = prev_ff;
		nxt_obj = obj_ff;
		nxt_bdir = bdir_ff;
		nxt_due = due_ff;
		nxt_ret = ret_ff;
		nxt_tgv = 1'b0;
		nxt_tgc = tgc_ff;
		nxt_tgk = tgk_ff;
		nxt_tgd = tgd_ff;
		act_c = pre_ff < 14'h2;
		cs_c = pre_ff[0];
		cfg = cfg_ff[cs_c];
		fn = cfg[`PBI_CF_FN +: 2];
		rcmd = cfg[`PBI_CF_RISE +: 2];
		rise_c = in_s2_ff[cs_c] && !prev_ff[cs_c];
		fall_c = !in_s2_ff[cs_c] && prev_ff[cs_c];
		proc_c = 1'b0;
		tmr = (timer_ff[cs_c] == 16'hffff) ? timer_ff[cs_c] : timer_ff[cs_c] + 16'h1;
		if (bus_s2_ff && !bus_prev_ff)
			nxt_ret = 2'h0;
		else if (act_c)
		begin
			nxt_prev[cs_c] = in_s2_ff[cs_c];
			nxt_timer[cs_c] = tmr;
			nxt_cyc[cs_c] = cyc_ff[cs_c] + 16'h1;
			if (fn == `PBI_FN_NONE || startup_act || ctrl_ff[`PBI_CT_DIS + 32'(cs_c)])
			begin
				nxt_state[cs_c] = PBI_IDLE;
				nxt_cyc[cs_c] = 16'h0;
				nxt_due[cs_c] = 1'b0;
			end
			else if (!ret_ff[cs_c])
			begin
				// Reaction once the startup delay has run out
				nxt_ret[cs_c] = 1'b1;
				nxt_cyc[cs_c] = 16'h0;
				nxt_state[cs_c] = PBI_IDLE;
				if (fn == `PBI_FN_SW)
				begin
					sc = sw_cmd(cfg[`PBI_CF_RET +: 2], obj_ff[cs_c]);
					val = sc[1] ? sc[0] : obj_ff[cs_c];
					nxt_obj[cs_c] = val;
					snd = sc[1];
					kind = PBI_TG_SWITCH;
					dat = {3'h0, val};
					nxt_due[cs_c] = (cfg[`PBI_CF_CYC +: 2] != 2'h0) && !sc[1];
				end
			end
			else
			begin
				proc_c = 1'b1;
				unique case (state_ff[cs_c])
					PBI_IDLE:
					begin
						if (fn == `PBI_FN_SW)
						begin
							sc = sw_cmd(rise_c ? rcmd : cfg[`PBI_CF_FALL +: 2], obj_ff[cs_c]);
							if ((rise_c || fall_c) && sc[1])
							begin
								nxt_obj[cs_c] = sc[0];
								snd = 1'b1;
								kind = PBI_TG_SWITCH;
								dat = {3'h0, sc[0]};
							end
						end
						else if (rise_c && rcmd != `PBI_CMD_NONE)
						begin
							nxt_timer[cs_c] = 16'h0;
							if (fn == `PBI_FN_DIM)
								nxt_state[cs_c] = PBI_WAIT;
							else
							begin
								dir = (rcmd == `PBI_CMD_TOG) ? ~bdir_ff[cs_c] : (rcmd == `PBI_CMD_B);
								nxt_bdir[cs_c] = dir;
								snd = 1'b1;
								dat = {3'h0, dir};
								kind = cfg[`PBI_CF_LS] ? PBI_TG_LONG : PBI_TG_SHORT;
								nxt_state[cs_c] = cfg[`PBI_CF_LS] ? PBI_SLAT : PBI_WAIT;
							end
						end
					end
					PBI_WAIT:
					begin
						if (fn == `PBI_FN_DIM && fall_c)
						begin
							sc = sw_cmd(rcmd, obj_ff[cs_c]);
							nxt_obj[cs_c] = sc[0];
							snd = 1'b1;
							kind = PBI_TG_SWITCH;
							dat = {3'h0, sc[0]};
							nxt_state[cs_c] = PBI_IDLE;
						end
						else if (fall_c)
							nxt_state[cs_c] = PBI_IDLE;
						else if (tmr >= tim_ff[cs_c][15:0])
						begin
							nxt_timer[cs_c] = 16'h0;
							snd = 1'b1;
							if (fn == `PBI_FN_DIM)
							begin
								dir = (rcmd == `PBI_CMD_TOG) ? ~obj_ff[cs_c] : (rcmd == `PBI_CMD_B);
								nxt_bdir[cs_c] = dir;
								kind = PBI_TG_DIM;
								dat = {dir, dir ? cfg[`PBI_CF_BSTEP +: 3] : cfg[`PBI_CF_DSTEP +: 3]};
								nxt_state[cs_c] = PBI_DIM;
							end
							else
							begin
								kind = PBI_TG_LONG;
								dat = {3'h0, bdir_ff[cs_c]};
								nxt_state[cs_c] = PBI_SLAT;
							end
						end
					end
					PBI_DIM:
					begin
						if (fall_c)
						begin
							snd = cfg[`PBI_CF_STOP];
							kind = PBI_TG_STOP;
							dat = 4'h0;
							nxt_state[cs_c] = PBI_IDLE;
						end
						else if (cfg[`PBI_CF_REP] && tmr >= rep_ff[cs_c][15:0])
						begin
							nxt_timer[cs_c] = 16'h0;
							snd = 1'b1;
							kind = PBI_TG_DIM;
							dir = bdir_ff[cs_c];
							dat = {dir, dir ? cfg[`PBI_CF_BSTEP +: 3] : cfg[`PBI_CF_DSTEP +: 3]};
						end
					end
					PBI_SLAT:
					begin
						if (fall_c)
						begin
							snd = 1'b1;
							kind = PBI_TG_SHORT;
							dat = {3'h0, bdir_ff[cs_c]};
							nxt_state[cs_c] = PBI_IDLE;
						end
						else if (tmr >= tim_ff[cs_c][31:16])
							nxt_state[cs_c] = PBI_HOLD;
					end
					PBI_HOLD:
					begin
						if (fall_c)
							nxt_state[cs_c] = PBI_IDLE;
					end
					default: nxt_state[cs_c] = PBI_IDLE;
				endcase
				// Cyclic repeat waits behind an edge telegram and behind the rate limit
				if (fn == `PBI_FN_SW && cfg[`PBI_CF_CYC +: 2] != 2'h0)
				begin
					if (rep_ff[cs_c][31:16] != 16'h0 && nxt_cyc[cs_c] >= rep_ff[cs_c][31:16])
					begin
						nxt_cyc[cs_c] = 16'h0;
						nxt_due[cs_c] = 1'b1;
					end
					if (due_ff[cs_c] && !snd && !rate_block)
					begin
						nxt_due[cs_c] = 1'b0;
						snd = cfg[`PBI_CF_CYC + 32'(obj_ff[cs_c])];
						kind = PBI_TG_SWITCH;
						dat = {3'h0, obj_ff[cs_c]};
					end
				end
			end
			if (snd)
			begin
				nxt_tgv = !rate_block;
				nxt_tgc = (fn == `PBI_FN_DIM && cfg[`PBI_CF_DUAL]) ? 1'b0 : cs_c;
				nxt_tgk = kind;
				nxt_tgd = dat;
			end
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pre_ff <= 14'h0;
			start_ff <= 16'h0;
			bus_s1_ff <= 1'b0;
			bus_s2_ff <= 1'b0;
			bus_prev_ff <= 1'b0;
			in_s1_ff <= 2'h0;
			in_s2_ff <= 2'h0;
			ctrl_ff <= `PBI_CTRL_RST;
			rdata_ff <= 32'h0;
			wait_ff <= 1'b1;
			prev_ff <= 2'h0;
			obj_ff <= 2'h0;
			bdir_ff <= 2'h0;
			due_ff <= 2'h0;
			ret_ff <= 2'h0;
			tgv_ff <= 1'b0;
			tgc_ff <= 1'b0;
			tgk_ff <= PBI_TG_NONE;
			tgd_ff <= 4'h0;
			for (int i = 0; i < 2; i++)
			begin
				cfg_ff[i] <= `PBI_CFG_RST;
				tim_ff[i] <= `PBI_TIM_RST;
				rep_ff[i] <= `PBI_REP_RST;
				state_ff[i] <= PBI_IDLE;
				timer_ff[i] <= 16'h0;
				cyc_ff[i] <= 16'h0;
			end
		end
		else
		begin
			pre_ff <= nxt_pre;
			start_ff <= nxt_start;
			bus_s1_ff <= bus_ok;
			bus_s2_ff <= bus_s1_ff;
			bus_prev_ff <= bus_s2_ff;
			in_s1_ff <= button_in;
			in_s2_ff <= in_s1_ff;
			ctrl_ff <= nxt_ctrl;
			rdata_ff <= nxt_rdata;
			wait_ff <= nxt_wait;
			prev_ff <= nxt_prev;
			obj_ff <= nxt_obj;
			bdir_ff <= nxt_bdir;
			due_ff <= nxt_due;
			ret_ff <= nxt_ret;
			tgv_ff <= nxt_tgv;
			tgc_ff <= nxt_tgc;
			tgk_ff <= nxt_tgk;
			tgd_ff <= nxt_tgd;
			cfg_ff <= nxt_cfg;
			tim_ff <= nxt_tim;
			rep_ff <= nxt_rep;
			state_ff <= nxt_state;
			timer_ff <= nxt_timer;
			cyc_ff <= nxt_cyc;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_none_quiet: assert property (tg_valid && tg_chan && $past(act_c) |-> $past(cfg_ff[1][1:0]) != `PBI_FN_NONE) else $error("telegram from inactive channel");
	a_startup_quiet: assert property (tg_valid |-> !$past(startup_act)) else $error("telegram in startup delay");
	a_rate_quiet: assert property (tg_valid |-> !$past(rate_block)) else $error("telegram under rate limit");
	a_toggle_inv: assert property (act_c && proc_c && rise_c && cfg_ff[cs_c][1:0] == `PBI_FN_SW && cfg_ff[cs_c][3:2] == `PBI_CMD_TOG && !rate_block |=> tg_valid && tg_kind == PBI_TG_SWITCH && tg_data[0] != $past(obj_ff[cs_c])) else $error("toggle did not invert");
	a_disable_cyc: assert property (act_c && ctrl_ff[`PBI_CT_DIS + 32'(cs_c)] |=> !tg_valid) else $error("disabled input sent");
	a_stop_release: assert property (act_c && proc_c && fall_c && state_ff[cs_c] == PBI_DIM && cfg_ff[cs_c][`PBI_CF_STOP] && !rate_block |=> tg_valid && tg_kind == PBI_TG_STOP) else $error("missing stop");
	a_slat_short: assert property (act_c && proc_c && fall_c && state_ff[cs_c] == PBI_SLAT && !rate_block |=> tg_valid && tg_kind == PBI_TG_SHORT) else $error("missing slat short");
	a_hold_silent: assert property (act_c && proc_c && state_ff[cs_c] == PBI_HOLD |=> !tg_valid) else $error("telegram after slat time");
	a_first_release: assert property (act_c && proc_c && fall_c && state_ff[cs_c] == PBI_WAIT && cfg_ff[cs_c][1:0] == `PBI_FN_BLIND |=> !tg_valid) else $error("release in first phase sent");
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bad wait timing");
endmodule

// *** rtl/pbi_defines.svh ***
// Constants for the two-channel push-button telegram block
// Functional notes
// - A channel set to no function is fully inactive and sends nothing.
// - Switching: rising and falling edges each pick off, on, toggle or no reaction.
// - Switching toggle inverts the stored object value and sends it.
// - Cyclic sending repeats the object value, even when the edge is no reaction.
// - Cyclic sending starts at return on matching value, never before 17 s if limited.
// - A disabled input sends no cyclic telegrams.
// - Dimming selects single-area or dual-area operation of the channel.
// - Darker/off: short press sends off, long press sends darker.
// - Brighter/on: short press sends on, long press sends brighter.
// - Dimming toggle: short press inverts the stored switching state and sends it.
// - Short/long split by configurable time; separate brighter and darker step widths.
// - Optional stop telegram on release after dimming.
// - Optional dimming repetition each configured interval while still pressed.
// - Short-long-short: rising edge sends short and starts first phase timer.
// - Short-long-short: first phase expiry sends long and starts slat timer.
// - Short-long-short: release during slat timer sends one more short.
// - Short-long-short: nothing more once slat timer has expired.
// - Long-short: rising edge sends long and starts slat timer.
// - Long-short: release during slat timer sends short.
// - Long-short: nothing more once slat timer has expired.
// - Blind rising-edge command sets direction up, down or toggle.
// - During shared startup delay all edges are discarded unevaluated.
// - With rate limit on, no telegram during first 17 s after return.
`ifndef PBI_DEFINES_SVH
`define PBI_DEFINES_SVH
`define PBI_OFS_CTRL 3'h0
`define PBI_OFS_CFG0 3'h1
`define PBI_OFS_CFG1 3'h2
`define PBI_OFS_TIM0 3'h3
`define PBI_OFS_TIM1 3'h4
`define PBI_OFS_REP0 3'h5
`define PBI_OFS_REP1 3'h6
`define PBI_OFS_STAT 3'h7
`define PBI_CT_RATE 16
`define PBI_CT_DIS 24
`define PBI_CF_FN 0
`define PBI_CF_RISE 2
`define PBI_CF_FALL 4
`define PBI_CF_RET 6
`define PBI_CF_CYC 8
`define PBI_CF_DUAL 10
`define PBI_CF_STOP 11
`define PBI_CF_REP 12
`define PBI_CF_LS 13
`define PBI_CF_BSTEP 16
`define PBI_CF_DSTEP 20
`define PBI_FN_NONE 2'h0
`define PBI_FN_SW 2'h1
`define PBI_FN_DIM 2'h2
`define PBI_FN_BLIND 2'h3
`define PBI_CMD_NONE 2'h0
`define PBI_CMD_A 2'h1
`define PBI_CMD_B 2'h2
`define PBI_CMD_TOG 2'h3
`define PBI_CTRL_RST 32'h0000_0000
`define PBI_CFG_RST 32'h0000_0000
`define PBI_TIM_RST 32'h0bb8_01f4
`define PBI_REP_RST 32'h0000_01f4
`define PBI_CLK_HZ 10000000
`define PBI_MS_NS 1000000
`define PBI_MS_CYCLES (`PBI_MS_NS / (1000000000 / `PBI_CLK_HZ))
`define PBI_RATE_S 17
`define PBI_RATE_MS (`PBI_RATE_S * 1000)
`endif

// *** rtl/pbi_pkg.sv ***
// Types for the push-button telegram block
package pbi_pkg;
	typedef enum logic [4:0]
	{
		PBI_IDLE = 5'b00001,
		PBI_WAIT = 5'b00010,
		PBI_DIM = 5'b00100,
		PBI_SLAT = 5'b01000,
		PBI_HOLD = 5'b10000
	} pbi_state_t;
	typedef enum logic [2:0]
	{
		PBI_TG_NONE = 3'h0,
		PBI_TG_SWITCH = 3'h1,
		PBI_TG_DIM = 3'h2,
		PBI_TG_STOP = 3'h3,
		PBI_TG_SHORT = 3'h4,
		PBI_TG_LONG = 3'h5
	} pbi_kind_t;
endpackage

// *** bench/pbi_bus_model.sv ***
// Far-side bus model that logs every telegram the block sends
`timescale 1ns/1ns
module pbi_bus_model
	import pbi_pkg::*;
(
	input wire logic clk,
	input wire logic tg_valid,
	input wire logic tg_chan,
	input wire pbi_kind_t tg_kind,
	input wire logic [3:0] tg_data
);
	// Actuators only listen; the queue lets the bench judge order as well as content
	logic [7:0] rx_q[$];
	always @(posedge clk)
		if (tg_valid === 1'b1)
			rx_q.push_back({tg_chan, tg_kind, tg_data});
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the two-input push-button telegram block
`timescale 1ns/1ns
module tb
	import pbi_pkg::*;
;
	logic clk, reset, bus_ok, avs_read, avs_write, avs_waitrequest, tg_valid, tg_chan;
	logic [1:0] button_in;
	logic [2:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable, tg_data;
	pbi_kind_t tg_kind;
	int failures = 0;
	int compares = 0;

	// Short ms and rate-limit spans keep the run to about a thousand cycles
	pbi_top #(.MS_CYCLES(4), .RATE_MS(20)) pbi_top_inst (.clk(clk), .reset(reset),
		.button_in(button_in), .bus_ok(bus_ok), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tg_valid(tg_valid), .tg_chan(tg_chan),
		.tg_kind(tg_kind), .tg_data(tg_data));
	pbi_bus_model pbi_bus_model_inst (.clk(clk), .tg_valid(tg_valid), .tg_chan(tg_chan),
		.tg_kind(tg_kind), .tg_data(tg_data));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic conclude();
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Holds the request until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_write <= wr;
		avs_read <= ~wr;
		avs_address <= a;
		avs_writedata <= d;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		cmp(n < 50, 1'b1, "bus answer");
	endtask

	task automatic wait_ms(input int n);
		repeat (n * 4) @(posedge clk);
	endtask

	task automatic hold(input int ch, input int on_ms);
		button_in[ch] <= 1'b1;
		wait_ms(on_ms);
		button_in[ch] <= 1'b0;
		wait_ms(5);
	endtask

	// Telegram as {chan, kind, data}; the mask hides fields that carry no meaning
	task automatic tg(input logic [7:0] exp, input logic [7:0] m, input string what);
		logic [7:0] got;
		got = 8'hxx;
		if (pbi_bus_model_inst.rx_q.size() > 0)
			got = pbi_bus_model_inst.rx_q.pop_front();
		cmp({24'h0, got & m}, {24'h0, exp & m}, what);
	endtask

	task automatic none(input string what);
		cmp(pbi_bus_model_inst.rx_q.size(), 32'h0, what);
		pbi_bus_model_inst.rx_q.delete();
	endtask

	task automatic s_regs();
		bus(1'b0, 3'h3, 32'h0);
		cmp(rd, 32'h0bb801f4, "timer reset");
		bus(1'b0, 3'h5, 32'h0);
		cmp(rd, 32'h000001f4, "repeat reset");
		bus(1'b0, 3'h1, 32'h0);
		cmp(rd, 32'h0, "config reset");
	endtask

	task automatic s_switch();
		bus(1'b1, 3'h1, 32'h00000019);
		none("idle");
		hold(0, 3);
		tg(8'h11, 8'hf1, "rise on");
		tg(8'h10, 8'hf1, "fall off");
		bus(1'b1, 3'h1, 32'h0000000d);
		hold(0, 3);
		tg(8'h11, 8'hf1, "toggle to on");
		none("fall no reaction");
		hold(0, 3);
		tg(8'h10, 8'hf1, "toggle to off");
		hold(1, 5);
		none("channel without function");
	endtask

	task automatic s_dim();
		bus(1'b1, 3'h3, 32'h000a0005);
		bus(1'b1, 3'h5, 32'h00000003);
		bus(1'b1, 3'h1, 32'h00301806);
		hold(0, 2);
		tg(8'h10, 8'hf1, "short darker");
		hold(0, 12);
		tg(8'h23, 8'hff, "long darker");
		tg(8'h23, 8'hff, "repeat darker");
		cmp(pbi_bus_model_inst.rx_q[$], 8'h30, "stop on release");
		pbi_bus_model_inst.rx_q.delete();
		bus(1'b1, 3'h1, 32'h0035000a);
		hold(0, 2);
		tg(8'h11, 8'hf1, "short brighter");
		hold(0, 8);
		tg(8'h2d, 8'hff, "long brighter");
		none("no stop, no repeat");
		bus(1'b1, 3'h1, 32'h0035000e);
		hold(0, 2);
		tg(8'h10, 8'hf1, "short toggle");
		hold(0, 8);
		tg(8'h2d, 8'hff, "long toggle from off");
		none("after toggle");
	endtask

	task automatic s_blind();
		bus(1'b1, 3'h4, 32'h00060004);
		bus(1'b1, 3'h2, 32'h0000000b);
		hold(1, 2);
		tg(8'hc1, 8'hf1, "short first");
		none("release in first phase");
		hold(1, 7);
		tg(8'hc1, 8'hf1, "short");
		tg(8'hd1, 8'hf1, "long after first phase");
		tg(8'hc1, 8'hf1, "short in slat time");
		hold(1, 14);
		tg(8'hc1, 8'hf1, "short");
		tg(8'hd1, 8'hf1, "long");
		none("past slat time");
		bus(1'b1, 3'h2, 32'h00000007);
		hold(1, 2);
		tg(8'hc0, 8'hf1, "up direction");
		bus(1'b1, 3'h2, 32'h0000200b);
		hold(1, 3);
		tg(8'hd1, 8'hf1, "long at press");
		tg(8'hc1, 8'hf1, "short in slat time");
		hold(1, 9);
		tg(8'hd1, 8'hf1, "long at press");
		none("past slat time");
		bus(1'b1, 3'h2, 32'h00000406);
		hold(1, 2);
		tg(8'h10, 8'hf1, "dual-area maps to group 0");
		none("after dual-area");
	endtask

	task automatic s_cyclic();
		bus(1'b1, 3'h5, 32'h00030000);
		bus(1'b1, 3'h1, 32'h00000301);
		pbi_bus_model_inst.rx_q.delete();
		hold(0, 2);
		wait_ms(6);
		cmp(pbi_bus_model_inst.rx_q.size() >= 2, 1'b1, "cyclic count");
		tg(8'h10, 8'hf0, "cyclic kind");
		bus(1'b1, 3'h0, 32'h01000000);
		wait_ms(2);
		pbi_bus_model_inst.rx_q.delete();
		hold(0, 2);
		wait_ms(8);
		none("disabled input");
		bus(1'b1, 3'h0, 32'h0);
		bus(1'b1, 3'h1, 32'h0);
		bus(1'b1, 3'h5, 32'h000001f4);
	endtask

	task automatic s_rate();
		bus(1'b1, 3'h1, 32'h00000019);
		bus(1'b1, 3'h0, 32'h00010005);
		bus_ok <= 1'b0;
		wait_ms(2);
		bus_ok <= 1'b1;
		wait_ms(1);
		pbi_bus_model_inst.rx_q.delete();
		hold(0, 2);
		none("inside startup delay");
		hold(0, 3);
		none("inside rate limit");
		wait_ms(14);
		pbi_bus_model_inst.rx_q.delete();
		hold(0, 3);
		tg(8'h11, 8'hf1, "after rate limit");
		tg(8'h10, 8'hf1, "after rate limit");
	endtask

	initial
	begin
		reset = 1'b1;
		bus_ok = 1'b1;
		button_in = 2'h0;
		avs_address = 3'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		wait_ms(3);
		s_regs();
		s_switch();
		s_dim();
		s_blind();
		s_cyclic();
		s_rate();
		conclude();
	end

	// Whole run needs well under a millisecond of simulated time
	initial
	begin
		#2000000;
		failures++;
		$display("wrong value at %0t: run did not finish", $time);
		conclude();
	end
endmodule
